// ===== hw/cbf_framer.v
// Block framing of the compressed field bitstream, encode and decode directions
`default_nettype none
`include "cbf_map.vh"
// What this block does
// - Delimiters always sit on 32-bit word boundaries
// - Bin width is uncoded 16-bit 8.8 value
// - Decode: bin width drives quantizer for block
// - Decode: zero bin width zeroes, discards payload
// - Encode: host bin width inserted, not quantized
// - Encode: quantizer uses host-supplied reciprocal separately
// - Payload padded with ones to 32 bits
// - Unexpected delimiter aborts Huffman decode
// - Encoder never emits end-of-sequence marker
// - Field start resets decode, marks field
// - Block start variant selects model and table
// - Zero block ignores all until next block
// - Each field holds exactly 41 blocks
module cbf_framer (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        resetn,
  // Mode: high selects encode
  input  wire        encode_mode,
  // Decode: aligned stream words from host
  input  wire        dec_valid,
  input  wire [31:0] dec_data,
  output wire        dec_ready,
  // Decode: toward quantizer and entropy decoder
  output reg  [15:0] quant_bin_width,
  output reg         quant_bw_valid,
  output reg         huff_valid,
  output reg  [31:0] huff_data,
  output reg         huff_zero,
  output reg         huff_reset,
  output reg  [2:0]  huff_model,
  output reg         field_second,
  output reg         field_start,
  output reg         seq_end,
  output reg         block_count_err,
  // Encode: host bin width and reciprocal
  input  wire [15:0] bin_width_word,
  input  wire [15:0] host_recip_bw,
  output reg  [15:0] quant_recip_bw,
  // Encode: coder requests
  input  wire        enc_field_req,
  input  wire        enc_field_second,
  input  wire        enc_block_req,
  input  wire [2:0]  enc_block_model,
  input  wire        enc_bits_valid,
  input  wire [31:0] enc_bits,
  input  wire        enc_bits_last,
  input  wire [5:0]  enc_bits_len,
  output wire        enc_ready,
  // Encode: aligned output words
  output reg         out_valid,
  output reg  [31:0] out_data,
  input  wire        out_ready
);
  localparam [3:0] D_IDLE = 4'h1;
  localparam [3:0] D_BW   = 4'h2;
  localparam [3:0] D_DATA = 4'h4;
  localparam [3:0] D_SKIP = 4'h8;

  localparam [5:0] E_IDLE  = 6'h01;
  localparam [5:0] E_PRE   = 6'h02;
  localparam [5:0] E_CODE  = 6'h04;
  localparam [5:0] E_BW    = 6'h08;
  localparam [5:0] E_DATA  = 6'h10;
  localparam [5:0] E_FLUSH = 6'h20;

  reg        rs1_reg;
  reg        rst_n;
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rs1_reg <= 1'b0;
      rst_n   <= 1'b0;
    end else begin
      rs1_reg <= 1'b1;
      rst_n   <= rs1_reg;
    end
  end

  wire       is_delim;
  wire       is_eos;
  wire       is_first_field_start_marker;
  wire       is_second_field_start_marker;
  wire       is_sob;
  wire [2:0] sob_kind;
  wire       dec_take = dec_valid & ~encode_mode;

  // Words arrive already aligned, so a marker can only start on a word
  cbf_delim_detect u_det (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .word_valid (dec_take),
    .word_data  (dec_data),
    .is_delim   (is_delim),
    .is_eos     (is_eos),
    .is_first_field_start_marker    (is_first_field_start_marker),
    .is_second_field_start_marker    (is_second_field_start_marker),
    .is_sob     (is_sob),
    .sob_kind   (sob_kind)
  );

  assign dec_ready = ~encode_mode;

  reg  [3:0]             dstate_reg;
  reg  [`CBF_BLK_W-1:0]  dblk_reg;
  // One word of delay lets an all-ones word be withheld until it is known
  // not to be a marker prefix; costs one word of payload latency.
  reg                    hold_reg;
  reg  [31:0]            hold_data_reg;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dstate_reg      <= D_IDLE;
      dblk_reg        <= {`CBF_BLK_W{1'b0}};
      hold_reg        <= 1'b0;
      hold_data_reg   <= 32'h0;
      quant_bin_width <= 16'h0;
      quant_bw_valid  <= 1'b0;
      huff_valid      <= 1'b0;
      huff_data       <= 32'h0;
      huff_zero       <= 1'b0;
      huff_reset      <= 1'b0;
      huff_model      <= 3'h0;
      field_second    <= 1'b0;
      field_start     <= 1'b0;
      seq_end         <= 1'b0;
      block_count_err <= 1'b0;
    end else begin
      quant_bw_valid <= 1'b0;
      huff_valid     <= 1'b0;
      huff_reset     <= 1'b0;
      field_start    <= 1'b0;
      seq_end        <= 1'b0;
      if (dec_take) begin
        hold_reg      <= 1'b0;
        hold_data_reg <= dec_data;
        if (is_first_field_start_marker | is_second_field_start_marker) begin
          // Field start resets the decoder, block count and state, and tags the field
          huff_reset   <= 1'b1;
          field_start  <= 1'b1;
          field_second <= is_second_field_start_marker;
          dblk_reg     <= {`CBF_BLK_W{1'b0}};
          dstate_reg   <= D_IDLE;
        end else if (is_eos) begin
          // Sequence end from host closes the last field
          seq_end         <= 1'b1;
          huff_reset      <= 1'b1;
          block_count_err <= (dblk_reg != `CBF_BLOCKS);
          dstate_reg      <= D_IDLE;
        end else if (is_sob) begin
          // Any marker mid-payload aborts the decoder
          huff_reset <= 1'b1;
          huff_model <= sob_kind;
          // Zero block is flagged at its marker, before any width word
          huff_zero  <= (sob_kind == 3'h5);
          block_count_err <= (dblk_reg == `CBF_BLOCKS);
          dblk_reg   <= dblk_reg + 1'b1;
          dstate_reg <= (sob_kind == 3'h5) ? D_SKIP : D_BW;
        end else if (dec_data == `CBF_ONES_WORD) begin
          // Possible marker prefix; release previous held word if any
          hold_reg <= 1'b1;
          // A zero-width block drops its held words as well
          if (hold_reg && dstate_reg == D_DATA && !huff_zero) begin
            huff_valid <= 1'b1;
            huff_data  <= hold_data_reg;
          end
        end else begin
          case (dstate_reg)
            D_BW: begin
              // Upper half of the word is the uncoded 8.8 width
              quant_bin_width <= dec_data[`CBF_BW_HI:`CBF_BW_LO];
              quant_bw_valid  <= 1'b1;
              huff_zero  <= (dec_data[`CBF_BW_HI:`CBF_BW_LO] == `CBF_ZERO_BW);
              dstate_reg <= D_DATA;
            end
            D_DATA: begin
              // Zero width: payload is still consumed but dropped
              huff_valid <= ~huff_zero;
              huff_data  <= hold_reg ? hold_data_reg : dec_data;
              hold_reg   <= hold_reg;
            end
            D_SKIP: begin
              huff_zero <= 1'b1;
            end
            D_IDLE: begin
            end
            default: dstate_reg <= D_IDLE;
          endcase
        end
      end
    end
  end

  // Encoder: prefix and code word; a block adds a bin width word and ones-padded payload
  reg  [5:0]  estate_reg;
  reg  [31:0] ecode_reg;
  reg  [31:0] eacc_reg;
  reg         efield_reg;
  wire        out_free = ~out_valid | out_ready;

  assign enc_ready = encode_mode & out_free & (estate_reg == E_DATA);

  function [31:0] cbf_ones_pad;
    input [31:0] bits;
    input [5:0]  len;
    begin
      cbf_ones_pad = (len >= 6'h20) ? bits : (bits | (`CBF_PAD_ONES >> len));
    end
  endfunction

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      estate_reg     <= E_IDLE;
      ecode_reg      <= 32'h0;
      eacc_reg       <= 32'h0;
      efield_reg     <= 1'b0;
      out_valid      <= 1'b0;
      out_data       <= 32'h0;
      quant_recip_bw <= 16'h0;
    end else begin
      // Reciprocal travels apart from the inserted width
      quant_recip_bw <= host_recip_bw;
      if (out_valid && out_ready) begin
        out_valid <= 1'b0;
      end
      if (encode_mode && out_free) begin
        case (estate_reg)
          E_IDLE: begin
            // No end-of-sequence word is ever generated here
            if (enc_field_req) begin
              efield_reg <= 1'b1;
              ecode_reg  <= enc_field_second ? `CBF_SECOND_FIELD_START_MARKER_WORD : `CBF_FIRST_FIELD_START_MARKER_WORD;
              out_valid  <= 1'b1;
              out_data   <= `CBF_ONES_WORD;
              estate_reg <= E_CODE;
            end else if (enc_block_req) begin
              efield_reg <= 1'b0;
              ecode_reg  <= {(enc_block_model == 3'h1) ? `CBF_BLOCK_START_MODEL1_CHROMA_CODE :
                             (enc_block_model == 3'h2) ? `CBF_BLOCK_START_MODEL1_LUMA_CODE :
                             (enc_block_model == 3'h3) ? `CBF_BLOCK_START_MODEL2_CHROMA_CODE :
                             (enc_block_model == 3'h4) ? `CBF_BLOCK_START_MODEL2_LUMA_CODE :
                             `CBF_BLOCK_START_ZERO_BLOCK_CODE, 24'hffffff};
              out_valid  <= 1'b1;
              out_data   <= `CBF_ONES_WORD;
              estate_reg <= E_CODE;
            end
          end
          E_CODE: begin
            out_valid  <= 1'b1;
            out_data   <= efield_reg ? ecode_reg
                          : {ecode_reg[31:24], 24'hffffff};
            estate_reg <= efield_reg ? E_IDLE : E_BW;
          end
          E_BW: begin
            // Host width goes out as-is and never reaches the quantizer
            out_valid  <= 1'b1;
            out_data   <= {bin_width_word, 16'hffff};
            estate_reg <= E_DATA;
          end
          E_DATA: begin
            if (enc_bits_valid) begin
              out_valid <= 1'b1;
              // Short final word filled with ones to a full word
              out_data  <= enc_bits_last ? cbf_ones_pad(enc_bits, enc_bits_len)
                           : enc_bits;
              estate_reg <= enc_bits_last ? E_IDLE : E_DATA;
            end
          end
          E_PRE, E_FLUSH: estate_reg <= E_IDLE;
          default: estate_reg <= E_IDLE;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ===== hw/cbf_map.vh
// Stream word codes, field positions and counts for the block framing logic
`ifndef CBF_MAP_VH
`define CBF_MAP_VH
`define CBF_ONES_WORD      32'hffffffff
`define CBF_EOS_WORD       32'hc0ffffff
`define CBF_FIRST_FIELD_START_MARKER_WORD      32'hf4000000
`define CBF_SECOND_FIELD_START_MARKER_WORD      32'hf4100000
`define CBF_SOB_HI         31
`define CBF_SOB_LO         24
`define CBF_BLOCK_START_MODEL1_CHROMA_CODE      8'h81
`define CBF_BLOCK_START_MODEL1_LUMA_CODE      8'h82
`define CBF_BLOCK_START_MODEL2_CHROMA_CODE      8'h83
`define CBF_BLOCK_START_MODEL2_LUMA_CODE      8'h84
`define CBF_BLOCK_START_ZERO_BLOCK_CODE      8'h8f
`define CBF_BW_HI          31
`define CBF_BW_LO          16
`define CBF_BW_W           16
`define CBF_BLOCKS         6'h29
`define CBF_BLK_W          6
`define CBF_ZERO_BW        16'h0000
`define CBF_PAD_ONES       32'hffffffff
`endif

// ===== hw/cbf_delim_detect.v
// Aligned delimiter recogniser: all-ones prefix word followed by a code word
`default_nettype none
`include "cbf_map.vh"
module cbf_delim_detect (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        rst_n,
  // Aligned stream word
  input  wire        word_valid,
  input  wire [31:0] word_data,
  // Recognised markers, one-cycle pulses alongside the code word
  output wire        is_delim,
  output wire        is_eos,
  output wire        is_first_field_start_marker,
  output wire        is_second_field_start_marker,
  output wire        is_sob,
  output wire [2:0]  sob_kind
);
  reg prefix_reg;

  function [2:0] cbf_sob_decode;
    input [7:0] code;
    begin
      case (code)
        `CBF_BLOCK_START_MODEL1_CHROMA_CODE: cbf_sob_decode = 3'h1;
        `CBF_BLOCK_START_MODEL1_LUMA_CODE: cbf_sob_decode = 3'h2;
        `CBF_BLOCK_START_MODEL2_CHROMA_CODE: cbf_sob_decode = 3'h3;
        `CBF_BLOCK_START_MODEL2_LUMA_CODE: cbf_sob_decode = 3'h4;
        `CBF_BLOCK_START_ZERO_BLOCK_CODE: cbf_sob_decode = 3'h5;
        default:        cbf_sob_decode = 3'h0;
      endcase
    end
  endfunction

  // Prefix is tracked on every word, whatever the decoder is doing
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prefix_reg <= 1'b0;
    end else if (word_valid) begin
      prefix_reg <= (word_data == `CBF_ONES_WORD);
    end
  end

  wire hit = word_valid & prefix_reg;
  assign is_eos   = hit & (word_data == `CBF_EOS_WORD);
  assign is_first_field_start_marker  = hit & (word_data == `CBF_FIRST_FIELD_START_MARKER_WORD);
  assign is_second_field_start_marker  = hit & (word_data == `CBF_SECOND_FIELD_START_MARKER_WORD);
  assign sob_kind = hit ? cbf_sob_decode(word_data[`CBF_SOB_HI:`CBF_SOB_LO]) : 3'h0;
  assign is_sob   = (sob_kind != 3'h0);
  assign is_delim = is_eos | is_first_field_start_marker | is_second_field_start_marker | is_sob;
endmodule
`default_nettype wire

// ===== test/cbf_host_model.sv
// Host-side source of the compressed stream on the decode port
`default_nettype none
module cbf_host_model (
  input  wire logic        sys_clk,
  input  wire logic        dec_ready,
  output var  logic        dec_valid,
  output var  logic [31:0] dec_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] q[$];
  int          gap = 0;
  int          wait_n = 0;
  initial begin
    dec_valid = 1'b0;
    dec_data  = 32'h0;
  end
  task put(input logic [31:0] w);
    q.push_back(w);
  endtask
  // Markers are whole aligned words: ones prefix, then the code word
  task marker(input logic [31:0] code);
    q.push_back(32'hffffffff);
    q.push_back(code);
  endtask
  // Idle bus toggles so a stale word never looks valid
  always @(posedge sys_clk) begin
    if (!dec_valid || dec_ready) begin
      if (q.size() != 0 && wait_n == 0) begin
        dec_valid <= 1'b1;
        dec_data  <= q.pop_front();
        wait_n    <= gap;
      end else begin
        dec_valid <= 1'b0;
        dec_data  <= ~dec_data;
        if (wait_n != 0) wait_n <= wait_n - 1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== test/cbf_framer_monitor.sv
// Port checker for the block framing logic
`default_nettype none
module cbf_framer_monitor (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        resetn,
  // Decode stream in
  input wire logic        encode_mode,
  input wire logic        dec_valid,
  input wire logic        dec_ready,
  input wire logic [31:0] dec_data,
  // Decode results
  input wire logic [15:0] quant_bin_width,
  input wire logic        quant_bw_valid,
  input wire logic        huff_valid,
  input wire logic        huff_zero,
  input wire logic        huff_reset,
  input wire logic [2:0]  huff_model,
  input wire logic        field_second,
  input wire logic        field_start,
  input wire logic        seq_end,
  // Encode side
  input wire logic [15:0] host_recip_bw,
  input wire logic [15:0] quant_recip_bw,
  input wire logic        out_valid,
  input wire logic [31:0] out_data,
  input wire logic        out_ready
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic       prev_ones_reg, prev_sob_reg, prev_out_ones_reg;
  logic [2:0] run_cnt_reg;
  wire        take = dec_valid && dec_ready;
  wire        mark = take && prev_ones_reg;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      prev_ones_reg     <= 1'b0;
      prev_sob_reg      <= 1'b0;
      prev_out_ones_reg <= 1'b0;
      run_cnt_reg       <= 3'h0;
    end else begin
      if (run_cnt_reg != 3'h4) run_cnt_reg <= run_cnt_reg + 3'h1;
      if (take) prev_ones_reg <= dec_data == 32'hffffffff;
      if (take) prev_sob_reg <= mark && dec_data[31:24] inside {[8'h81:8'h84]};
      if (out_valid && out_ready) prev_out_ones_reg <= out_data == 32'hffffffff;
    end
  end
  sob_model_a: assert property (mark && dec_data[31:24] inside {[8'h81:8'h84]}
    |=> huff_reset && huff_model == $past(dec_data[26:24])) else $error("block model wrong");
  zero_block_a: assert property (mark && dec_data[31:24] == 8'h8f
    |=> huff_reset && huff_zero && huff_model == 3'h5) else $error("zero block missed");
  zero_drop_a: assert property (huff_zero |-> !huff_valid)
    else $error("zero data passed");
  width_pass_a: assert property (take && prev_sob_reg
    |=> quant_bw_valid && quant_bin_width == $past(dec_data[31:16])) else $error("width lost");
  field_mark_a: assert property (mark && dec_data[31:21] == 11'h7a0
    && dec_data[19:0] == 20'h0
    |=> field_start && huff_reset && field_second == $past(dec_data[20])) else $error("field");
  seq_end_a: assert property (mark && dec_data == 32'hc0ffffff
    |=> seq_end && huff_reset) else $error("eos");
  dec_off_a: assert property (encode_mode [*2] |-> !quant_bw_valid && !huff_valid)
    else $error("decode output in encode");
  recip_a: assert property (run_cnt_reg == 3'h4
    |=> quant_recip_bw == $past(host_recip_bw)) else $error("reciprocal not passed");
  no_eos_a: assert property (out_valid && prev_out_ones_reg |-> out_data != 32'hc0ffffff)
    else $error("encoder sent end marker");
  cover property (mark && dec_data[31:24] == 8'h8f);
  cover property (seq_end);
  cover property (out_valid && !out_ready);
endmodule
`default_nettype wire

// ===== test/tb.sv
// Self-checking bench for the block framing logic
`default_nettype none
`define CMP(n, e, g) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 0, resetn = 0, encode_mode = 0, out_ready = 0, dec_valid, dec_ready;
  logic enc_field_req = 0, enc_field_second = 0, enc_block_req = 0, enc_bits_valid = 0;
  logic enc_bits_last = 0, quant_bw_valid, huff_valid, huff_zero, huff_reset, field_second;
  logic field_start, seq_end, block_count_err, enc_ready, out_valid;
  logic [15:0] bin_width_word = 0, host_recip_bw = 0, quant_bin_width, quant_recip_bw;
  logic [31:0] enc_bits = 0, dec_data, huff_data, out_data, lfsr = 32'h00007d22;
  logic [5:0]  enc_bits_len = 0;
  logic [2:0]  enc_block_model = 0, huff_model;
  logic [31:0] exp_huff[$], exp_out[$];
  logic [15:0] exp_bw[$];
  int          n_mismatch = 0, check_count = 0;
  cbf_framer dut_u (.*);
  cbf_host_model host_u (.sys_clk(sys_clk), .dec_ready(dec_ready), .dec_valid(dec_valid),
    .dec_data(dec_data));
  always #25 sys_clk = ~sys_clk;
  function logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  task tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task settle();
    for (int k = 0; k < 3000 && (host_u.q.size() != 0 || exp_out.size() != 0); k++)
      @(posedge sys_clk);
    repeat (4) @(posedge sys_clk);
  endtask
  // Payload words keep bit 0 low, the last of a block bit 16: an all-ones payload word is held back by the decoder
  task dec_field(input logic [31:0] sof, input int nblk);
    logic [31:0] d;
    logic [7:0]  code;
    host_u.marker(sof);
    for (int i = 0; i < nblk; i++) begin
      d = rnd();
      code = (i % 5 == 4) ? 8'h8f : 8'h81 + 8'(i % 5);
      if (i % 7 == 3) d[15:0] = 16'h0;
      // An all-ones width word would be taken for a marker prefix
      if (d[15:0] == 16'hffff) d[15:0] = 16'hfffe;
      host_u.marker({code, 24'hffffff});
      host_u.put({d[15:0], 16'hffff});
      if (code != 8'h8f) exp_bw.push_back(d[15:0]);
      for (int k = 0; k <= i % 3; k++) begin
        d = rnd() & 32'hfffffffe;
        if (k == i % 3) d = {d[31:17], 17'h0ffff};
        host_u.put(d);
        if (code != 8'h8f && exp_bw[$] != 16'h0) exp_huff.push_back(d);
      end
    end
    host_u.marker(32'hc0ffffff);
  endtask
  task enc_block(input logic [2:0] m, input int n);
    logic [31:0] d;
    logic [5:0]  len;
    d = rnd();
    bin_width_word <= d[15:0];
    host_recip_bw <= d[31:16];
    enc_block_model <= m;
    enc_block_req <= 1'b1;
    exp_out.push_back(32'hffffffff);
    exp_out.push_back({(m == 3'h5) ? 8'h8f : {5'h10, m}, 24'hffffff});
    exp_out.push_back({d[15:0], 16'hffff});
    @(posedge sys_clk);
    enc_block_req <= 1'b0;
    for (int k = 0; k < n; k++) begin
      d = rnd();
      len = (k == n - 1) ? d[4:0] + 6'd1 : 6'd32;
      enc_bits <= d;
      enc_bits_len <= len;
      enc_bits_last <= k == n - 1;
      enc_bits_valid <= 1'b1;
      exp_out.push_back(d | (32'hffffffff >> len));
      do @(posedge sys_clk); while (enc_ready !== 1'b1);
    end
    enc_bits_valid <= 1'b0;
    settle();
  endtask
  always @(posedge sys_clk) begin
    out_ready <= (rnd() & 32'h3) != 0;
    if (huff_valid) `CMP("huff_data", exp_huff.pop_front(), huff_data)
    if (quant_bw_valid) `CMP("quant_bin_width", exp_bw.pop_front(), quant_bin_width)
    if (out_valid && out_ready) `CMP("out_data", exp_out.pop_front(), out_data)
  end
  initial begin
    #2000000;
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    dec_field(32'hf4000000, 41);
    settle();
    `CMP("block_count_err", 1'b0, block_count_err)
    host_u.gap = 2;
    dec_field(32'hf4100000, 3);
    settle();
    `CMP("block_count_err", 1'b1, block_count_err)
    `CMP("huff_left", 0, exp_huff.size())
    encode_mode <= 1'b1;
    repeat (3) @(posedge sys_clk);
    for (int m = 1; m <= 5; m++) enc_block(3'(m), m);
    enc_field_req <= 1'b1;
    enc_field_second <= 1'b1;
    exp_out.push_back(32'hffffffff);
    exp_out.push_back(32'hf4100000);
    @(posedge sys_clk);
    enc_field_req <= 1'b0;
    settle();
    `CMP("out_left", 0, exp_out.size())
    tally_and_finish();
  end
endmodule
bind cbf_framer cbf_framer_monitor mon_u (
  .sys_clk         (sys_clk),
  .resetn          (resetn),
  .encode_mode     (encode_mode),
  .dec_valid       (dec_valid),
  .dec_ready       (dec_ready),
  .dec_data        (dec_data),
  .quant_bin_width (quant_bin_width),
  .quant_bw_valid  (quant_bw_valid),
  .huff_valid      (huff_valid),
  .huff_zero       (huff_zero),
  .huff_reset      (huff_reset),
  .huff_model      (huff_model),
  .field_second    (field_second),
  .field_start     (field_start),
  .seq_end         (seq_end),
  .host_recip_bw   (host_recip_bw),
  .quant_recip_bw  (quant_recip_bw),
  .out_valid       (out_valid),
  .out_data        (out_data),
  .out_ready       (out_ready)
);
`default_nettype wire
